//--- hw/activity_detect.sv
// one sync activity detector: two-stage synchroniser, edge seen within a window
module activity_detect
  import sync_ctl_pkg::*;
#(
  parameter int unsigned WIN = ACT_WINDOW
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic sig_in,
  output logic      active
);
  typedef struct packed {
    logic        s1;
    logic        s2;
    logic        s3;
    logic        seen;
    logic        act;
    logic [15:0] cnt;
    logic [1:0]  fill;
  } det_t;

  det_t st_q;
  det_t st_d;

  always_comb begin
    logic edge_now;
    // chain still filling after reset: an idle-high pin must not read as an edge
    edge_now = (st_q.fill == ACT_SYNC_FULL) && (st_q.s2 != st_q.s3);
    st_d     = st_q;
    st_d.s1  = sig_in;
    st_d.s2  = st_q.s1;
    st_d.s3  = st_q.s2;
    if (st_q.fill != ACT_SYNC_FULL) begin
      st_d.fill = st_q.fill + 2'b01;
    end
    if (edge_now) begin
      st_d.seen = 1'b1;
    end
    if (st_q.cnt == 16'(WIN - 1)) begin
      // no edge in a whole window means the sync is gone
      st_d.cnt  = 16'h0000;
      st_d.act  = st_q.seen || edge_now;
      st_d.seen = 1'b0;
    end else begin
      st_d.cnt = st_q.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign active = st_q.act;
endmodule : activity_detect

//--- hw/sync_clamp_coast_control_regs.sv
// register slice for sync source, clamp, coast, output and status control
module sync_clamp_coast_control_regs
  import sync_ctl_pkg::*;
(
  input  wire logic       MCLK,
  input  wire logic       RST,
  input  wire logic       CE,
  input  wire reg_req_t   REQ,
  input  wire sync_in_t   SYNC_IN,
  output logic [7:0]      RDATA,
  output logic            RVALID,
  output ctl_out_t        CTL
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] if_sel;
    logic [7:0] sync_source_select;
    logic [7:0] clamp_coast_control;
    logic [7:0] precoast_count;
    logic [7:0] postcoast_count;
    logic [7:0] output_and_power_control;
    logic [7:0] status_snap;
    logic [7:0] rdata;
    logic       rvalid;
    logic [1:0] link_sync;
  } state_t;

  state_t st_q;
  state_t st_d;

  logic hs_act;
  logic sog_act;
  logic vs_act;
  logic link_act;
  logic digital_sel;
  logic [7:0] status_live;

  // ------------------------------------------------------------
  // activity detectors
  // ------------------------------------------------------------
  activity_detect u_hs (
    .clk    (MCLK),
    .rst    (RST),
    .ce     (CE),
    .sig_in (SYNC_IN.hsync_pin),
    .active (hs_act)
  );

  activity_detect u_sog (
    .clk    (MCLK),
    .rst    (RST),
    .ce     (CE),
    .sig_in (SYNC_IN.green_sync),
    .active (sog_act)
  );

  activity_detect u_vs (
    .clk    (MCLK),
    .rst    (RST),
    .ce     (CE),
    .sig_in (SYNC_IN.vsync_pin),
    .active (vs_act)
  );

  assign link_act = st_q.link_sync[1];

  // ------------------------------------------------------------
  // source selection
  // ------------------------------------------------------------
  always_comb begin
    logic analog_act;
    analog_act = hs_act || sog_act;
    if (st_q.if_sel[IF_OVR_BIT] || (analog_act && link_act)) begin
      digital_sel = st_q.if_sel[IF_SEL_BIT];
    end else begin
      digital_sel = link_act;
    end
  end

  always_comb begin
    status_live              = ZERO8;
    status_live[ST_HS_BIT]   = hs_act;
    status_live[ST_SOG_BIT]  = sog_act;
    status_live[ST_VS_BIT]   = vs_act;
    status_live[ST_LINK_BIT] = link_act;
    status_live[ST_IF_BIT]   = digital_sel;
  end

  // ------------------------------------------------------------
  // register access
  // ------------------------------------------------------------
  always_comb begin
    st_d           = st_q;
    st_d.rvalid    = 1'b0;
    st_d.link_sync = {st_q.link_sync[0], SYNC_IN.link_clk_seen};
    // one snapshot per cycle keeps the bits of a read coherent
    st_d.status_snap = status_live;
    if (REQ.wr) begin
      unique case (REQ.addr)
        ADDR_IF_SEL:      st_d.if_sel                   = REQ.wdata;
        ADDR_SYNC_SRC:    st_d.sync_source_select       = REQ.wdata;
        ADDR_CLAMP_COAST: st_d.clamp_coast_control      = REQ.wdata;
        ADDR_PRECOAST:    st_d.precoast_count           = REQ.wdata;
        ADDR_POSTCOAST:   st_d.postcoast_count          = REQ.wdata;
        ADDR_OUT_PWR:     st_d.output_and_power_control = REQ.wdata;
        default: ;
      endcase
    end
    if (REQ.rd) begin
      st_d.rvalid = 1'b1;
      unique case (REQ.addr)
        ADDR_IF_SEL:      st_d.rdata = st_q.if_sel;
        ADDR_SYNC_SRC:    st_d.rdata = st_q.sync_source_select;
        ADDR_CLAMP_COAST: st_d.rdata = st_q.clamp_coast_control;
        ADDR_PRECOAST:    st_d.rdata = st_q.precoast_count;
        ADDR_POSTCOAST:   st_d.rdata = st_q.postcoast_count;
        ADDR_OUT_PWR:     st_d.rdata = st_q.output_and_power_control;
        ADDR_STATUS:      st_d.rdata = st_q.status_snap;
        default:          st_d.rdata = ZERO8;
      endcase
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      st_q                          <= '0;
      st_q.if_sel                   <= RST_IF_SEL;
      st_q.sync_source_select       <= RST_SYNC_SRC;
      st_q.clamp_coast_control      <= RST_CLAMP_COAST;
      st_q.precoast_count           <= RST_PRECOAST;
      st_q.postcoast_count          <= RST_POSTCOAST;
      st_q.output_and_power_control <= RST_OUT_PWR;
    end else if (CE) begin
      st_q <= st_d;
    end
  end

  // ------------------------------------------------------------
  // control outputs
  // ------------------------------------------------------------
  logic [7:0] ss;
  logic [7:0] cc;
  logic [7:0] op;
  assign ss = st_q.sync_source_select;
  assign cc = st_q.clamp_coast_control;
  assign op = st_q.output_and_power_control;

  always_comb begin
    if (ss[HS_OVR_BIT] || (hs_act && sog_act)) begin
      CTL.hsync_from_green = ss[HS_SEL_BIT];
    end else begin
      CTL.hsync_from_green = sog_act && !hs_act;
    end
    if (ss[VS_OVR_BIT]) begin
      CTL.vsync_from_sep = ss[VS_SEL_BIT];
    end else begin
      // no dedicated vsync seen: fall back to the separator
      CTL.vsync_from_sep = !vs_act;
    end
    CTL.vsync_invert     = !ss[VS_POL_BIT];
    CTL.clamp_enable     = !cc[CLAMP_OFF_BIT];
    CTL.clamp_midscale   = {cc[CLAMP_R_BIT], cc[CLAMP_G_BIT], cc[CLAMP_B_BIT]};
    CTL.coast_enable     = cc[COAST_EN_BIT];
    CTL.coast_pol_forced = cc[COAST_OVR_BIT];
    // polarity from the host only when forced; else device reports high by default
    CTL.coast_pol_high   = cc[COAST_OVR_BIT] ? cc[COAST_POL_BIT] : 1'b1;
    CTL.precoast         = st_q.precoast_count;
    CTL.postcoast        = st_q.postcoast_count;
    // inversion matters only while the digital link is in use
    CTL.link_clk_invert  = op[CLK_INV_BIT] && digital_sel;
    CTL.pixel_data_outputs_hiz = op[TRI_BIT];
    CTL.hdcp_addr        = HDCP_ADDR_BITS;
    CTL.power_down       = !op[PWR_BIT];
    CTL.out_422          = op[YUV422_BIT];
    CTL.digital_active   = digital_sel;
  end

  assign RDATA  = st_q.rdata;
  assign RVALID = st_q.rvalid;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_hs_override: assert property (@(posedge MCLK) disable iff (RST)
    ss[HS_OVR_BIT] |-> CTL.hsync_from_green == ss[HS_SEL_BIT])
    else $error("hsync override not honoured");

  a_vs_override: assert property (@(posedge MCLK) disable iff (RST)
    ss[VS_OVR_BIT] |-> CTL.vsync_from_sep == ss[VS_SEL_BIT])
    else $error("vsync override not honoured");

  a_vs_polarity: assert property (@(posedge MCLK) disable iff (RST)
    (CE && REQ.wr && REQ.addr == ADDR_SYNC_SRC) |=>
      CTL.vsync_invert == !$past(REQ.wdata[VS_POL_BIT]))
    else $error("vsync polarity wrong");

  a_clamp_write: assert property (@(posedge MCLK) disable iff (RST)
    (CE && REQ.wr && REQ.addr == ADDR_CLAMP_COAST) |=> (!CE ||
      CTL.clamp_enable == !$past(REQ.wdata[CLAMP_OFF_BIT])))
    else $error("clamp enable did not follow write");

  a_precoast_wr: assert property (@(posedge MCLK) disable iff (RST)
    (CE && REQ.wr && REQ.addr == ADDR_PRECOAST) |=> (!CE ||
      CTL.precoast == $past(REQ.wdata)))
    else $error("precoast not stored");

  a_power_down: assert property (@(posedge MCLK) disable iff (RST)
    (CE && REQ.wr && REQ.addr == ADDR_OUT_PWR) |=>
      CTL.power_down == !$past(REQ.wdata[PWR_BIT]))
    else $error("power-down bit not applied");

  a_status_read: assert property (@(posedge MCLK) disable iff (RST)
    (CE && REQ.rd && REQ.addr == ADDR_STATUS) |=> (RVALID &&
      RDATA == $past(st_q.status_snap)))
    else $error("status read mismatch");

  a_if_override: assert property (@(posedge MCLK) disable iff (RST)
    st_q.if_sel[IF_OVR_BIT] |-> CTL.digital_active == st_q.if_sel[IF_SEL_BIT])
    else $error("interface override ignored");

  a_hiz_follow: assert property (@(posedge MCLK) disable iff (RST)
    (CE && REQ.wr && REQ.addr == ADDR_OUT_PWR) |=>
      (CTL.pixel_data_outputs_hiz == $past(REQ.wdata[TRI_BIT]) &&
       CTL.hdcp_addr == HDCP_ADDR_BITS))
    else $error("three-state or slave address wrong");

  a_hs_sel_write: assert property (@(posedge MCLK) disable iff (RST)
    (CE && REQ.wr && REQ.addr == ADDR_SYNC_SRC && REQ.wdata[HS_OVR_BIT]) |=>
      CTL.hsync_from_green == $past(REQ.wdata[HS_SEL_BIT]))
    else $error("hsync select write not applied");

  a_hs_both_seen: assert property (@(posedge MCLK) disable iff (RST)
    (!ss[HS_OVR_BIT] && hs_act && sog_act) |->
      CTL.hsync_from_green == ss[HS_SEL_BIT])
    else $error("hsync select ignored with both syncs present");

  a_hs_auto_pin: assert property (@(posedge MCLK) disable iff (RST)
    (!ss[HS_OVR_BIT] && hs_act && !sog_act) |->
      !CTL.hsync_from_green)
    else $error("hsync taken from green with only the pin active");

  a_vs_sel_write: assert property (@(posedge MCLK) disable iff (RST)
    (CE && REQ.wr && REQ.addr == ADDR_SYNC_SRC && REQ.wdata[VS_OVR_BIT]) |=>
      CTL.vsync_from_sep == $past(REQ.wdata[VS_SEL_BIT]))
    else $error("vsync select write not applied");

  a_clamp_levels: assert property (@(posedge MCLK) disable iff (RST)
    (CE && REQ.wr && REQ.addr == ADDR_CLAMP_COAST) |=>
      CTL.clamp_midscale == $past(REQ.wdata[CLAMP_R_BIT:CLAMP_B_BIT]))
    else $error("clamp levels did not follow write");

  a_coast_select: assert property (@(posedge MCLK) disable iff (RST)
    (CE && REQ.wr && REQ.addr == ADDR_CLAMP_COAST) |=>
      CTL.coast_enable == $past(REQ.wdata[COAST_EN_BIT]))
    else $error("coast select did not follow write");

  a_coast_forced: assert property (@(posedge MCLK) disable iff (RST)
    cc[COAST_OVR_BIT] |->
      (CTL.coast_pol_forced && CTL.coast_pol_high == cc[COAST_POL_BIT]))
    else $error("forced coast polarity not used");

  a_coast_auto: assert property (@(posedge MCLK) disable iff (RST)
    !cc[COAST_OVR_BIT] |->
      !CTL.coast_pol_forced)
    else $error("coast polarity forced without override");

  a_postcoast_wr: assert property (@(posedge MCLK) disable iff (RST)
    (CE && REQ.wr && REQ.addr == ADDR_POSTCOAST) |=>
      CTL.postcoast == $past(REQ.wdata))
    else $error("postcoast not stored");

  a_clk_inv_write: assert property (@(posedge MCLK) disable iff (RST)
    (CE && REQ.wr && REQ.addr == ADDR_OUT_PWR) |=>
      CTL.link_clk_invert == ($past(REQ.wdata[CLK_INV_BIT]) && digital_sel))
    else $error("link clock invert did not follow write");

  a_clk_inv_analog: assert property (@(posedge MCLK) disable iff (RST)
    !digital_sel |->
      !CTL.link_clk_invert)
    else $error("link clock inverted while analog is active");

  a_out_422_write: assert property (@(posedge MCLK) disable iff (RST)
    (CE && REQ.wr && REQ.addr == ADDR_OUT_PWR) |=>
      CTL.out_422 == $past(REQ.wdata[YUV422_BIT]))
    else $error("output mode did not follow write");

  a_status_sync: assert property (@(posedge MCLK) disable iff (RST)
    CE |=> (st_q.status_snap[ST_HS_BIT] == $past(hs_act) &&
      st_q.status_snap[ST_SOG_BIT] == $past(sog_act) &&
      st_q.status_snap[ST_VS_BIT] == $past(vs_act)))
    else $error("sync activity status not captured");

  a_status_link: assert property (@(posedge MCLK) disable iff (RST)
    CE |=>
      st_q.status_snap[ST_LINK_BIT] == $past(link_act))
    else $error("link clock status not captured");

  a_link_sync: assert property (@(posedge MCLK) disable iff (RST)
    CE |=>
      st_q.link_sync[1] == $past(st_q.link_sync[0]))
    else $error("link flag synchroniser broken");

  a_status_iface: assert property (@(posedge MCLK) disable iff (RST)
    CE |=>
      st_q.status_snap[ST_IF_BIT] == $past(digital_sel))
    else $error("active interface status not captured");

  a_iface_both: assert property (@(posedge MCLK) disable iff (RST)
    (!st_q.if_sel[IF_OVR_BIT] && (hs_act || sog_act) && link_act) |->
      CTL.digital_active == st_q.if_sel[IF_SEL_BIT])
    else $error("interface select ignored with both active");

  a_iface_auto: assert property (@(posedge MCLK) disable iff (RST)
    (!st_q.if_sel[IF_OVR_BIT] && !hs_act && !sog_act) |->
      CTL.digital_active == link_act)
    else $error("active interface does not follow the link");

  a_status_ro: assert property (@(posedge MCLK) disable iff (RST)
    (CE && REQ.wr && REQ.addr == ADDR_STATUS) |=>
      ($stable(st_q.if_sel) && $stable(st_q.sync_source_select) &&
       $stable(st_q.clamp_coast_control) && $stable(st_q.output_and_power_control)))
    else $error("write to status changed a register");

  a_unmapped_read: assert property (@(posedge MCLK) disable iff (RST)
    (CE && REQ.rd && !(REQ.addr inside {[ADDR_IF_SEL:ADDR_STATUS]})) |=>
      (RVALID && RDATA == ZERO8))
    else $error("unmapped read not zero");

  a_rvalid_pulse: assert property (@(posedge MCLK) disable iff (RST)
    RVALID |=>
      (!RVALID || $past(REQ.rd) || !$past(CE)))
    else $error("read valid longer than one cycle");

  a_rdata_hold: assert property (@(posedge MCLK) disable iff (RST)
    !(CE && REQ.rd) |=>
      $stable(RDATA))
    else $error("read data moved without a read");

  a_ce_freeze: assert property (@(posedge MCLK) disable iff (RST)
    !CE |=>
      $stable(st_q))
    else $error("state moved with clock enable low");

  a_reset_regs: assert property (@(posedge MCLK) disable iff (RST)
    $past(RST) |->
      (st_q.precoast_count == RST_PRECOAST && st_q.postcoast_count == RST_POSTCOAST &&
       st_q.clamp_coast_control == RST_CLAMP_COAST))
    else $error("register reset values wrong");

  a_reset_ctl: assert property (@(posedge MCLK) disable iff (RST)
    $past(RST) |->
      (CTL.vsync_invert && CTL.clamp_enable && CTL.coast_enable && !CTL.power_down))
    else $error("control levels after reset wrong");

endmodule : sync_clamp_coast_control_regs

//--- hw/sync_ctl_pkg.sv
// constants, register map and carrier types for the sync, clamp and coast control registers
package sync_ctl_pkg;

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_IF_SEL      = 8'h0f;
  localparam logic [7:0] ADDR_SYNC_SRC    = 8'h10;
  localparam logic [7:0] ADDR_CLAMP_COAST = 8'h11;
  localparam logic [7:0] ADDR_PRECOAST    = 8'h12;
  localparam logic [7:0] ADDR_POSTCOAST   = 8'h13;
  localparam logic [7:0] ADDR_OUT_PWR     = 8'h14;
  localparam logic [7:0] ADDR_STATUS      = 8'h15;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int IF_OVR_BIT    = 2;
  localparam int IF_SEL_BIT    = 1;
  localparam int HS_OVR_BIT    = 4;
  localparam int HS_SEL_BIT    = 3;
  localparam int VS_POL_BIT    = 2;
  localparam int VS_OVR_BIT    = 1;
  localparam int VS_SEL_BIT    = 0;
  localparam int CLAMP_OFF_BIT = 7;
  localparam int CLAMP_R_BIT   = 6;
  localparam int CLAMP_G_BIT   = 5;
  localparam int CLAMP_B_BIT   = 4;
  localparam int COAST_EN_BIT  = 3;
  localparam int COAST_OVR_BIT = 2;
  localparam int COAST_POL_BIT = 1;
  localparam int CLK_INV_BIT   = 4;
  localparam int TRI_BIT       = 3;
  localparam int HDCP_A1_BIT   = 2;
  localparam int PWR_BIT       = 1;
  localparam int YUV422_BIT    = 0;
  localparam int ST_HS_BIT     = 7;
  localparam int ST_SOG_BIT    = 6;
  localparam int ST_VS_BIT     = 5;
  localparam int ST_LINK_BIT   = 4;
  localparam int ST_IF_BIT     = 3;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [7:0] RST_IF_SEL      = 8'h78;
  localparam logic [7:0] RST_SYNC_SRC    = 8'h40;
  localparam logic [7:0] RST_CLAMP_COAST = 8'h0a;
  localparam logic [7:0] RST_PRECOAST    = 8'h00;
  localparam logic [7:0] RST_POSTCOAST   = 8'h00;
  localparam logic [7:0] RST_OUT_PWR     = 8'he2;
  localparam logic [1:0] HDCP_ADDR_BITS  = 2'b10;
  localparam logic [7:0] ZERO8           = 8'h00;

  // ------------------------------------------------------------
  // activity detection
  // ------------------------------------------------------------
  // a sync line with no edge for a whole window reads as absent
  localparam int unsigned ACT_WINDOW    = 4000;
  localparam logic [1:0]  ACT_SYNC_FULL = 2'b11;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic hsync_pin;
    logic green_sync;
    logic vsync_pin;
    logic sep_vsync;
    logic link_clk_seen;
  } sync_in_t;

  typedef struct packed {
    logic       hsync_from_green;
    logic       vsync_from_sep;
    logic       vsync_invert;
    logic       clamp_enable;
    logic [2:0] clamp_midscale;
    logic       coast_enable;
    logic       coast_pol_forced;
    logic       coast_pol_high;
    logic [7:0] precoast;
    logic [7:0] postcoast;
    logic       link_clk_invert;
    logic       pixel_data_outputs_hiz;
    logic [1:0] hdcp_addr;
    logic       power_down;
    logic       out_422;
    logic       digital_active;
  } ctl_out_t;

endpackage : sync_ctl_pkg

//--- verification/graphics_source.sv
// graphics source model driving the sync inputs and the link clock flag
module graphics_source
  import sync_ctl_pkg::*;
(
  input  wire logic       clk,
  input  wire logic [4:0] en,
  output sync_in_t        sig
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt = 8'h00;
  // a disabled sync line sits still, so its detector sees no edge at all
  always @(posedge clk) begin
    cnt <= cnt + 8'h01;
  end
  // link flag is a level: the receiver reports clock present, not edges
  assign sig = {en[4:1] & cnt[7:4], en[0]};
endmodule : graphics_source

//--- verification/sync_clamp_coast_control_regs_tb.sv
// self-checking bench: register map, control outputs and sync activity status
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module sync_clamp_coast_control_regs_tb
  import sync_ctl_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic       MCLK = 1'b0;
  logic       RST  = 1'b1;
  logic       CE   = 1'b1;
  reg_req_t   REQ  = '0;
  logic [4:0] src_en = 5'h00;
  sync_in_t   SYNC_IN;
  logic [7:0] RDATA;
  logic       RVALID;
  ctl_out_t   CTL;
  int         err_total = 0;
  int         tests_run = 0;
  logic [7:0] mdl [logic [7:0]];
  logic [7:0] rd_v;
  logic [7:0] k;
  logic [4:0] cfg [5] = '{5'h10, 5'h08, 5'h06, 5'h01, 5'h1f};

  always #5 MCLK = ~MCLK;

  graphics_source graphics_source_i (.clk(MCLK), .en(src_en), .sig(SYNC_IN));
  sync_clamp_coast_control_regs sync_clamp_coast_control_regs_i (
    .MCLK(MCLK), .RST(RST), .CE(CE), .REQ(REQ), .SYNC_IN(SYNC_IN),
    .RDATA(RDATA), .RVALID(RVALID), .CTL(CTL));

  // ------------------------------------------------------------
  // behavioural model
  // ------------------------------------------------------------
  function automatic logic dig_exp();
    logic an;
    an = src_en[4] | src_en[3];
    if (mdl[ADDR_IF_SEL][IF_OVR_BIT] || (an && src_en[0])) begin
      return mdl[ADDR_IF_SEL][IF_SEL_BIT];
    end
    return src_en[0];
  endfunction : dig_exp

  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    if (mdl.exists(a)) begin
      return mdl[a];
    end
    if (a == 8'h15) begin
      return {src_en[4:2], src_en[0], dig_exp(), 3'b000};
    end
    return 8'h00;
  endfunction : exp_rd

  // bits outside this slice are not compared
  function automatic logic [7:0] msk(input logic [7:0] a);
    return (a == 8'h11) ? 8'hfe : (a == 8'h14) ? 8'hfb : (a == 8'h15) ? 8'hf8 : 8'hff;
  endfunction : msk

  function automatic ctl_out_t exp_ctl();
    ctl_out_t c;
    logic [7:0] s, q, o;
    s = mdl[8'h10];
    q = mdl[8'h11];
    o = mdl[8'h14];
    c.hsync_from_green = (s[HS_OVR_BIT] || (src_en[4] && src_en[3])) ? s[HS_SEL_BIT]
                         : (src_en[3] && !src_en[4]);
    c.vsync_from_sep = s[VS_OVR_BIT] ? s[VS_SEL_BIT] : !src_en[2];
    c.vsync_invert = !s[VS_POL_BIT];
    c.clamp_enable = !q[CLAMP_OFF_BIT];
    c.clamp_midscale = q[6:4];
    c.coast_enable = q[COAST_EN_BIT];
    c.coast_pol_forced = q[COAST_OVR_BIT];
    c.coast_pol_high = q[COAST_OVR_BIT] ? q[COAST_POL_BIT] : 1'b1;
    c.precoast = mdl[8'h12];
    c.postcoast = mdl[8'h13];
    c.digital_active = dig_exp();
    c.link_clk_invert = o[CLK_INV_BIT] && c.digital_active;
    c.pixel_data_outputs_hiz = o[TRI_BIT];
    c.hdcp_addr = 2'b10;
    c.power_down = !o[PWR_BIT];
    c.out_422 = o[YUV422_BIT];
    return c;
  endfunction : exp_ctl

  // ------------------------------------------------------------
  // bus tasks and closing report
  // ------------------------------------------------------------
  task automatic test_done();
    $display("counts: tests_run=%0d err_total=%0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge MCLK);
    REQ <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge MCLK);
    REQ.wr <= 1'b0;
    if (CE && mdl.exists(a)) begin
      mdl[a] = d;
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n = 0;
    @(negedge MCLK);
    REQ <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge MCLK);
    REQ.rd <= 1'b0;
    while (RVALID !== 1'b1 && n < 4) begin
      @(negedge MCLK);
      n++;
    end
    if (n == 4) begin
      err_total++;
      test_done();
    end
    d = RDATA;
  endtask : rd

  task automatic chk_rd(input logic [7:0] a);
    rd(a, rd_v);
    `CHK(rd_v & msk(a), exp_rd(a) & msk(a))
  endtask : chk_rd

  // detectors work on long windows, so poll the status until it agrees
  task automatic settle();
    int n = 0;
    rd(ADDR_STATUS, rd_v);
    while ((rd_v & 8'hf8) !== exp_rd(8'h15) && n < 60) begin
      repeat (200) @(negedge MCLK);
      rd(ADDR_STATUS, rd_v);
      n++;
    end
    if ((rd_v & 8'hf8) !== exp_rd(8'h15)) begin
      err_total++;
      test_done();
    end
    chk_rd(ADDR_STATUS);
    `CHK(CTL, exp_ctl())
  endtask : settle

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'h4e23bb18));
    mdl[8'h0f] = 8'h78;
    mdl[8'h10] = 8'h40;
    mdl[8'h11] = 8'h0a;
    mdl[8'h12] = 8'h00;
    mdl[8'h13] = 8'h00;
    mdl[8'h14] = 8'he2;
    repeat (3) @(negedge MCLK);
    RST <= 1'b0;
    for (int a = 8'h0f; a <= 8'h15; a++) chk_rd(8'(a));
    `CHK(CTL, exp_ctl())
    $display("test reset values done");
    for (int i = 0; i < 40; i++) begin
      wr(8'(8'h0f + $urandom_range(5)), 8'($urandom));
      chk_rd(8'(8'h0f + $urandom_range(5)));
      `CHK(CTL, exp_ctl())
    end
    wr(ADDR_CLAMP_COAST, 8'h06);
    `CHK(CTL, exp_ctl())
    $display("test random writes done");
    wr(ADDR_STATUS, 8'hff);
    wr(8'h20, 8'hff);
    chk_rd(8'h20);
    chk_rd(ADDR_STATUS);
    CE <= 1'b0;
    wr(ADDR_PRECOAST, 8'h5a);
    CE <= 1'b1;
    chk_rd(ADDR_PRECOAST);
    $display("test refusals done");
    foreach (cfg[i]) begin
      src_en = cfg[i];
      for (int j = 0; j < 4; j++) begin
        k = 8'($urandom);
        wr(ADDR_IF_SEL, {5'h0f, 2'(j), 1'b0});
        wr(ADDR_SYNC_SRC, k);
        settle();
      end
    end
    $display("test sync activity done");
    test_done();
  end
endmodule : sync_clamp_coast_control_regs_tb
